// ===== src/ccfc_crc.sv
// byte-wide reflected crc-16, lsb of each byte folded first
`default_nettype none
module ccfc_crc (
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // engine side
  ccfc_crc_if.calc  bus
);
  logic [15:0] crc_q;
  logic [15:0] start;

  // one byte, eight serial steps, lsb first as on the wire
  function automatic logic [15:0] ccfc_fold(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ ccfc_pkg::CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction : ccfc_fold

  // init with valid folds the first byte onto the preset
  assign start   = bus.init ? ccfc_pkg::CRC_PRESET : crc_q;
  assign bus.crc = crc_q;

  // running remainder
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      crc_q <= ccfc_pkg::CRC_PRESET;
    end else if (clk_en && bus.valid) begin
      crc_q <= ccfc_fold(start, bus.data);
    end else if (clk_en && bus.init) begin
      crc_q <= ccfc_pkg::CRC_PRESET;
    end
  end
endmodule : ccfc_crc
`default_nettype wire

// ===== src/ccfc_crc_if.sv
// interface between the frame engine and the crc unit
`default_nettype none
interface ccfc_crc_if;
  logic        init;
  logic        valid;
  logic [7:0]  data;
  logic [15:0] crc;
  modport eng  (output init, output valid, output data, input crc);
  modport calc (input init, input valid, input data, output crc);
endinterface : ccfc_crc_if
`default_nettype wire

// ===== src/ccfc_engine.sv
// command frame receiver, crc checker, register executor and responder
// Behaviour
// - read payload byte is byte count minus one, 0 gives 1, 0x7F gives 128
// - write payload goes to consecutive registers from the frame pointer
// - crc-16 x^16+x^15+x^2+1, all-ones preset, reflected division
// - crc runs over whole frame with check bytes; zero remainder means good
// - crc checked first; a bad frame is dropped, not executed nor answered
// - bad crc reports only the crc fault, no other frame error
// - every byte is relayed onward even when the frame is bad
// - transmitter crc covers all bytes but the check bytes, lsb first
// - commands run only after a good crc, before any register access
// - single read answered only by the device whose identity matches
// - single write updates up to eight registers in order
// - write length field is register count minus one
// - single write executed only by the device whose identity matches
// - single read header is 0x80
// - single write header is 0x90 plus data bytes minus one
// - response data are register contents ascending from echoed pointer
// - stack read answered by each device with its stack flag set
// - header bit 7 command, bits 6..4 request, bits 2..0 length minus one
// - response header low seven bits hold data bytes minus one
// - identity byte absent in stack frames, always in responses, top bits 0
// - unimplemented register writes ignored, reads return zero
`default_nettype none
module ccfc_engine (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // incoming byte stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  // relayed byte stream
  output logic             fwd_valid,
  output logic      [7:0]  fwd_data,
  // response byte stream
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        tx_ready,
  // device register space
  output logic      [15:0] reg_addr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic        reg_hit
);
  ////////////////////////////////////////////////////////////////////////////
  ccfc_pkg::ccfc_state_t state_q, state_d;
  logic [9:0]  link_control_reg_q;
  logic        crc_fault_q, rsvd_q;
  logic [15:0] good_cnt_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;
  logic        fwd_valid_q, tx_valid_q, reg_wr_q, reg_rd_q;
  logic [7:0]  fwd_data_q, tx_data_q, reg_wdata_q;
  logic [15:0] reg_addr_q;
  logic [7:0]  hdr_q, pos_q, len_q, idx_q, rbyte_q;
  logic [5:0]  id_q;
  logic [15:0] addr_q;
  logic [7:0]  wbuf_q [8];
  logic [2:0]  widx_q;
  logic        have_q, rd_pend_q;
  ccfc_crc_if  crc_bus ();

  ccfc_crc u_crc (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .bus     (crc_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // header decode, for the byte arriving in idle and for the held header
  wire [2:0]  in_req    = rx_data[6:4];
  wire        in_cmd    = rx_data[ccfc_pkg::HDR_CMD_BIT];
  wire        in_has_id = in_cmd && (in_req == ccfc_pkg::REQ_SREAD ||
                                     in_req == ccfc_pkg::REQ_SWRITE);
  wire        in_is_wr  = in_cmd && in_req[0] && (in_req != ccfc_pkg::REQ_RSVD);
  wire [7:0]  in_dlen   = in_is_wr ? {5'h00, rx_data[2:0]} + 8'h01 : 8'h01;
  wire [7:0]  in_len    = in_cmd ? ccfc_pkg::HDR_FIXED + {7'h00, in_has_id} + in_dlen + 8'h02
                                 : {1'b0, rx_data[6:0]} + ccfc_pkg::RESP_FIXED;
  wire [2:0]  req       = hdr_q[6:4];
  wire        is_cmd    = hdr_q[ccfc_pkg::HDR_CMD_BIT];
  wire        has_id    = is_cmd && (req == ccfc_pkg::REQ_SREAD || req == ccfc_pkg::REQ_SWRITE);
  wire [7:0]  doff      = ccfc_pkg::HDR_FIXED + {7'h00, has_id};
  wire [7:0]  didx      = pos_q - doff;
  wire [5:0]  dev_id    = link_control_reg_q[ccfc_pkg::CTRL_ID_LSB +: 6];
  wire        stack_dev = link_control_reg_q[ccfc_pkg::CTRL_STACK_BIT];

  // verdict in the check state
  wire        crc_ok    = (crc_bus.crc == ccfc_pkg::CRC_GOOD);
  wire        id_match  = (id_q == dev_id);
  wire        go_write  = is_cmd && req == ccfc_pkg::REQ_SWRITE && id_match;
  wire        go_read   = is_cmd && ((req == ccfc_pkg::REQ_SREAD && id_match) ||
                                     (req == ccfc_pkg::REQ_STKREAD && stack_dev));
  wire        in_check  = (state_q == ccfc_pkg::CCFC_CHECK);
  wire        bad_frame = in_check && !crc_ok;
  wire        start_rd  = in_check && crc_ok && go_read;

  // response byte layout: header, id, pointer, data, crc low, crc high
  wire [6:0]  rcnt      = wbuf_q[0][6:0];
  wire [7:0]  rlast     = {1'b0, rcnt} + ccfc_pkg::RESP_FIXED - 8'h01;
  wire [7:0]  ridx      = idx_q - 8'h04;
  wire        is_data   = idx_q >= 8'h04 && ridx <= {1'b0, rcnt};
  wire        is_crcb   = idx_q >= rlast - 8'h01;
  wire [7:0]  tx_byte   = idx_q == 8'h00 ? {1'b0, rcnt} :
                          idx_q == 8'h01 ? {2'b00, dev_id} :
                          idx_q == 8'h02 ? addr_q[15:8] :
                          idx_q == 8'h03 ? addr_q[7:0] :
                          is_data        ? rbyte_q :
                          idx_q == rlast ? crc_bus.crc[15:8] : crc_bus.crc[7:0];
  wire        in_resp   = (state_q == ccfc_pkg::CCFC_RESP);
  wire        tx_load   = in_resp && !tx_valid_q && (!is_data || have_q);
  wire        tx_done   = in_resp && tx_valid_q && tx_ready;
  wire        rx_take   = rx_valid && (state_q == ccfc_pkg::CCFC_IDLE ||
                                       state_q == ccfc_pkg::CCFC_RX);

  // crc feed: received bytes, then outgoing bytes except the check bytes
  assign crc_bus.init  = (state_q == ccfc_pkg::CCFC_IDLE && rx_valid) || start_rd;
  assign crc_bus.valid = rx_take || (tx_load && !is_crcb);
  assign crc_bus.data  = in_resp ? tx_byte : rx_data;

  ////////////////////////////////////////////////////////////////////////////
  // next state; a bad frame goes straight back to idle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ccfc_pkg::CCFC_IDLE:  if (rx_valid) state_d = ccfc_pkg::CCFC_RX;
      ccfc_pkg::CCFC_RX:    if (rx_valid && pos_q == len_q - 8'h01) state_d = ccfc_pkg::CCFC_CHECK;
      ccfc_pkg::CCFC_CHECK: begin
        if (!crc_ok)       state_d = ccfc_pkg::CCFC_IDLE;
        else if (go_write) state_d = ccfc_pkg::CCFC_WRITE;
        else if (go_read)  state_d = ccfc_pkg::CCFC_RESP;
        else               state_d = ccfc_pkg::CCFC_IDLE;
      end
      ccfc_pkg::CCFC_WRITE: if (widx_q == hdr_q[2:0]) state_d = ccfc_pkg::CCFC_IDLE;
      ccfc_pkg::CCFC_RESP:  if (tx_done && idx_q == rlast) state_d = ccfc_pkg::CCFC_IDLE;
      default:              state_d = ccfc_pkg::CCFC_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ccfc_pkg::CCFC_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // relay every byte regardless of frame health
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fwd_valid_q <= 1'b0;
      fwd_data_q  <= 8'h00;
    end else if (clk_en) begin
      fwd_valid_q <= rx_valid;
      fwd_data_q  <= rx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame capture: header, identity, pointer, payload
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hdr_q  <= 8'h00;
      pos_q  <= 8'h00;
      len_q  <= 8'h00;
      id_q   <= 6'h00;
      addr_q <= 16'h0000;
      for (int i = 0; i < 8; i++) wbuf_q[i] <= 8'h00;
    end else if (clk_en && rx_take) begin
      if (state_q == ccfc_pkg::CCFC_IDLE) begin
        hdr_q <= rx_data;
        len_q <= in_len;
        pos_q <= 8'h01;
      end else begin
        pos_q <= pos_q + 8'h01;
        if (has_id && pos_q == 8'h01) id_q <= rx_data[5:0];
        if (pos_q == doff - 8'h02) addr_q[15:8] <= rx_data;
        if (pos_q == doff - 8'h01) addr_q[7:0] <= rx_data;
        // response frames passing through only touch the buffer harmlessly
        if (pos_q >= doff && didx < ccfc_pkg::WBUF_DEPTH) wbuf_q[didx[2:0]] <= rx_data;
      end
    end
  end

  // register port: writes in order, reads one byte at a time
  // read data is registered on the far side, so it is taken the cycle after the strobe
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      widx_q      <= 3'h0;
      reg_wr_q    <= 1'b0;
      reg_rd_q    <= 1'b0;
      reg_addr_q  <= 16'h0000;
      reg_wdata_q <= 8'h00;
      rd_pend_q   <= 1'b0;
      have_q      <= 1'b0;
      rbyte_q     <= 8'h00;
    end else if (clk_en) begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      if (state_q == ccfc_pkg::CCFC_WRITE) begin
        reg_wr_q    <= 1'b1;
        reg_addr_q  <= addr_q + {13'h0000, widx_q};
        reg_wdata_q <= wbuf_q[widx_q];
        widx_q      <= widx_q + 3'h1;
      end else begin
        widx_q <= 3'h0;
      end
      if (in_resp && is_data && !have_q && !rd_pend_q) begin
        reg_rd_q   <= 1'b1;
        reg_addr_q <= addr_q + {8'h00, ridx};
        rd_pend_q  <= 1'b1;
      end
      if (rd_pend_q && !reg_rd_q) begin
        rbyte_q   <= reg_hit ? reg_rdata : 8'h00;
        have_q    <= 1'b1;
        rd_pend_q <= 1'b0;
      end
      if (tx_done) have_q <= 1'b0;
    end
  end

  // response transmitter, one byte held until taken
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_valid_q <= 1'b0;
      tx_data_q  <= 8'h00;
      idx_q      <= 8'h00;
    end else if (clk_en) begin
      if (start_rd) idx_q <= 8'h00;
      if (tx_load) begin
        tx_valid_q <= 1'b1;
        tx_data_q  <= tx_byte;
      end
      if (tx_done) begin
        tx_valid_q <= 1'b0;
        idx_q      <= idx_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave with one wait state; unmapped offsets answer with an error
  wire        apb_setup = psel && penable && !pready_q;
  wire        apb_done  = psel && penable && pready_q;
  wire        hit_ctrl  = (paddr == ccfc_pkg::OFS_LINK_CTRL);
  wire        hit_stat  = (paddr == ccfc_pkg::OFS_LINK_STATUS);
  wire        w1c_crc   = apb_done && pwrite && hit_stat && pwdata[ccfc_pkg::STAT_CRC_BIT];
  wire        w1c_rsvd  = apb_done && pwrite && hit_stat && pwdata[ccfc_pkg::STAT_RSVD_BIT];
  wire        rsvd_seen = in_check && crc_ok && is_cmd && req == ccfc_pkg::REQ_RSVD;
  wire [31:0] stat_word = {good_cnt_q, 7'h00, (state_q != ccfc_pkg::CCFC_IDLE),
                           6'h00, rsvd_q, crc_fault_q};
  wire [31:0] rd_word   = hit_ctrl ? {22'h00_0000, link_control_reg_q} :
                          hit_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup && !hit_ctrl && !hit_stat;
      if (apb_setup && !pwrite) prdata_q <= rd_word;
    end
  end

  // control and sticky status; a hardware set beats a software clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      link_control_reg_q <= ccfc_pkg::CTRL_RESET;
      crc_fault_q        <= 1'b0;
      rsvd_q             <= 1'b0;
      good_cnt_q         <= 16'h0000;
    end else if (clk_en) begin
      if (apb_done && pwrite && hit_ctrl) link_control_reg_q <= pwdata[9:0];
      crc_fault_q <= bad_frame || (crc_fault_q && !w1c_crc);
      rsvd_q      <= rsvd_seen || (rsvd_q && !w1c_rsvd);
      if (in_check && crc_ok) good_cnt_q <= good_cnt_q + 16'h0001;
    end
  end

  // outputs straight from flops
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign fwd_valid = fwd_valid_q;
  assign fwd_data  = fwd_data_q;
  assign tx_valid  = tx_valid_q;
  assign tx_data   = tx_data_q;
  assign reg_addr  = reg_addr_q;
  assign reg_wdata = reg_wdata_q;
  assign reg_wr    = reg_wr_q;
  assign reg_rd    = reg_rd_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks, counted on enabled edges only
  default clocking ccfc_cb @(posedge clock iff clk_en); endclocking
  default disable iff (sys_rst);

  sequence s_bad_check;
    in_check && !crc_ok;
  endsequence
  sequence s_fetch_miss;
    reg_rd_q ##1 !reg_hit;
  endsequence

  bad_drop_a: assert property (s_bad_check |=> state_q == ccfc_pkg::CCFC_IDLE
                               ##1 (!reg_wr_q && !tx_valid_q))
    else $error("bad crc frame was not dropped");
  fault_flag_a: assert property (s_bad_check |=> crc_fault_q && !rsvd_seen)
    else $error("crc fault not flagged");
  relay_byte_a: assert property (rx_valid |=> fwd_valid_q && fwd_data_q == $past(rx_data))
    else $error("byte not relayed");
  exec_good_a: assert property ($rose(reg_wr_q) |-> $past(state_q, 2) == ccfc_pkg::CCFC_CHECK
                                && $past(crc_ok, 2))
    else $error("write without a good crc");
  write_span_a: assert property (reg_wr_q |-> reg_addr_q - addr_q < 16'h0008)
    else $error("write beyond eight registers");
  resp_head_a: assert property (tx_valid_q && idx_q == 8'h00 |-> tx_data_q == {1'b0, rcnt})
    else $error("response header wrong");
  resp_id_a: assert property (tx_valid_q && idx_q == 8'h01 |-> tx_data_q[7:6] == 2'b00
                              && tx_data_q[5:0] == dev_id)
    else $error("response identity wrong");
  miss_zero_a: assert property (s_fetch_miss |-> ##1 rbyte_q == 8'h00)
    else $error("unimplemented read not zero");
  target_only_a: assert property (in_check && crc_ok && is_cmd && req == ccfc_pkg::REQ_SREAD
                                  && !id_match |=> state_q == ccfc_pkg::CCFC_IDLE)
    else $error("foreign read answered");
endmodule : ccfc_engine
`default_nettype wire

// ===== src/ccfc_pkg.sv
// constants shared by the chain command frame engine and its crc unit
`default_nettype none
package ccfc_pkg;
  // apb register byte offsets
  localparam logic [11:0] OFS_LINK_CTRL   = 12'h000;
  localparam logic [11:0] OFS_LINK_STATUS = 12'h004;
  // link control register fields
  localparam int          CTRL_ID_LSB     = 0;
  localparam int          CTRL_STACK_BIT  = 8;
  localparam int          CTRL_TOP_BIT    = 9;
  localparam logic [9:0]  CTRL_RESET      = 10'h000;
  // link status register fields
  localparam int          STAT_CRC_BIT    = 0;
  localparam int          STAT_RSVD_BIT   = 1;
  localparam int          STAT_BUSY_BIT   = 8;
  localparam int          STAT_GOOD_LSB   = 16;
  // frame header layout and request codes
  localparam int          HDR_CMD_BIT     = 7;
  localparam logic [2:0]  REQ_SREAD       = 3'h0;
  localparam logic [2:0]  REQ_SWRITE      = 3'h1;
  localparam logic [2:0]  REQ_STKREAD     = 3'h2;
  localparam logic [2:0]  REQ_RSVD        = 3'h7;
  localparam logic [7:0]  HDR_FIXED       = 8'h03;
  localparam logic [7:0]  RESP_FIXED      = 8'h07;
  localparam logic [7:0]  WBUF_DEPTH      = 8'h08;
  // crc: reflected form of x^16+x^15+x^2+1, all-ones preset
  localparam logic [15:0] CRC_PRESET      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REFL   = 16'hA001;
  localparam logic [15:0] CRC_GOOD        = 16'h0000;
  // engine states, gray along idle-rx-check-write; check to resp flips two bits
  typedef enum logic [2:0] {
    CCFC_IDLE  = 3'b000,
    CCFC_RX    = 3'b001,
    CCFC_CHECK = 3'b011,
    CCFC_WRITE = 3'b010,
    CCFC_RESP  = 3'b110
  } ccfc_state_t;
endpackage : ccfc_pkg
`default_nettype wire

// ===== verification/ccfc_regspace_model.sv
// register space and response sink on the far side of the frame engine
`default_nettype none
module ccfc_regspace_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // register space
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_hit,
  // response sink
  output logic             tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [32];
  logic [1:0] stall_q;
  wire        impl = reg_addr < 16'h0020;
  initial foreach (mem_q[i]) mem_q[i] = 8'h00;
  // only the low 32 addresses exist, so long reads run into holes
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stall_q   <= 2'h0;
      reg_hit   <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      stall_q <= stall_q + 2'h1;
      if (reg_wr && impl) mem_q[reg_addr[4:0]] <= reg_wdata;
      // idle data lines invert so a stale byte never passes for a hole
      reg_rdata <= (reg_rd && impl) ? mem_q[reg_addr[4:0]] : ~reg_rdata;
      reg_hit   <= reg_rd && impl;
    end
  end
  // sink stalls one cycle in four
  assign tx_ready = stall_q != 2'h3;
endmodule : ccfc_regspace_model
`default_nettype wire

// ===== verification/test_chain_command_frame_crc.sv
// self-checking bench for the chain command frame engine
`default_nettype none
module test_chain_command_frame_crc;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, sys_rst, psel, penable, pwrite, rx_valid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, fwd_valid, tx_valid, tx_ready;
  logic [7:0]  rx_data, fwd_data, tx_data, reg_wdata, reg_rdata;
  logic [15:0] reg_addr;
  logic        reg_wr, reg_rd, reg_hit;
  int          miscompares, checks;
  logic [7:0]  txq[$];
  logic [7:0]  fwdq[$];
  logic [7:0]  shd [32];
  ccfc_engine dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
    .fwd_valid(fwd_valid), .fwd_data(fwd_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
  ccfc_regspace_model part_u (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .tx_ready(tx_ready));
  always #20 clock = ~clock;
  // accepted response bytes and relayed bytes
  always @(posedge clock) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_data);
    if (fwd_valid === 1'b1) fwdq.push_back(fwd_data);
  end
  ////////////////////////////////////////////////////////////////////////////
  // reflected crc, lsb of each byte first
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc16
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic give_verdict;
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // one apb transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // no cycle count assumed; the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // sends a frame with its crc, low byte first; bad spoils the check
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = crc16(f);
    f.push_back(c[7:0] ^ {7'h00, bad});
    f.push_back(c[15:8]);
    fwdq.delete();
    txq.delete();
    foreach (f[i]) begin
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_data  <= f[i];
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    repeat (2) @(posedge clock);
    chk("relayed bytes", f.size(), fwdq.size());
    foreach (f[i]) if (i < fwdq.size()) chk("relayed byte", f[i], fwdq[i]);
    // bytes sent while the engine writes or answers are not parsed, so wait here
    wait_idle();
  endtask : send
  // busy polling bounds every wait on the engine
  task automatic wait_idle;
    for (int i = 0; i < 500; i++) begin
      apb(1'b0, ccfc_pkg::OFS_LINK_STATUS, 32'h0000_0000);
      if (rd[ccfc_pkg::STAT_BUSY_BIT] === 1'b0) break;
    end
    chk("engine idle", 32'h0000_0000, {31'h0, rd[ccfc_pkg::STAT_BUSY_BIT]});
  endtask : wait_idle
  task automatic expect_resp(input logic [7:0] e[$]);
    logic [15:0] c;
    c = crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    wait_idle();
    chk("resp length", e.size(), txq.size());
    foreach (e[i]) if (i < txq.size()) chk("resp byte", e[i], txq[i]);
    chk("resp crc", 32'h0000_0000, crc16(txq));
  endtask : expect_resp
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, ccfc_pkg::OFS_LINK_CTRL, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0000, rd);
    apb(1'b1, ccfc_pkg::OFS_LINK_CTRL, 32'h0000_0105);
    apb(1'b0, ccfc_pkg::OFS_LINK_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_0105, rd);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
  endtask : t_regs
  // eight-byte write at the top of the space, then a two-byte overwrite
  task automatic t_write;
    logic [7:0] f[$];
    f = {8'h97, 8'h05, 8'h00, 8'h18};
    for (int i = 0; i < 8; i++) begin
      f.push_back(8'h10 + i[7:0]);
      shd[24+i] = 8'h10 + i[7:0];
    end
    send(f, 1'b0);
    send({8'h91, 8'h05, 8'h00, 8'h1E, 8'hA5, 8'h5A}, 1'b0);
    shd[30] = 8'hA5;
    shd[31] = 8'h5A;
    wait_idle();
    for (int i = 24; i < 32; i++) chk("reg", shd[i], part_u.mem_q[i]);
    chk("good frames", 32'h0000_0002, rd[31:16]);
  endtask : t_write
  task automatic t_badcrc;
    send({8'h90, 8'h05, 8'h00, 8'h1E, 8'h33}, 1'b1);
    send({8'hF0, 8'h00, 8'h1E, 8'h33}, 1'b1);
    wait_idle();
    chk("bad write", 32'h0000_00A5, part_u.mem_q[30]);
    chk("crc fault", 32'h0000_0001, rd[1:0]);
    chk("good frames", 32'h0000_0002, rd[31:16]);
    apb(1'b1, ccfc_pkg::OFS_LINK_STATUS, 32'h0000_0001);
    apb(1'b0, ccfc_pkg::OFS_LINK_STATUS, 32'h0000_0000);
    chk("fault cleared", 32'h0000_0000, rd[1:0]);
    send({8'hF0, 8'h00, 8'h1E, 8'h33}, 1'b0);
    chk("reserved seen", 32'h0000_0002, rd[1:0]);
  endtask : t_badcrc
  // longest read, running past the implemented space into holes
  task automatic t_read;
    logic [7:0] e[$];
    send({8'h80, 8'h05, 8'h00, 8'h00, 8'h7F}, 1'b0);
    e = {8'h7F, 8'h05, 8'h00, 8'h00};
    for (int i = 0; i < 128; i++) e.push_back(i < 32 ? shd[i] : 8'h00);
    expect_resp(e);
  endtask : t_read
  task automatic t_other;
    send({8'h80, 8'h07, 8'h00, 8'h1E, 8'h00}, 1'b0);
    chk("no answer", 32'h0000_0000, txq.size());
    send({8'h90, 8'h07, 8'h00, 8'h1E, 8'h77}, 1'b0);
    wait_idle();
    chk("no write", 32'h0000_00A5, part_u.mem_q[30]);
  endtask : t_other
  task automatic t_stack;
    send({8'hA0, 8'h00, 8'h1E, 8'h00}, 1'b0);
    expect_resp({8'h00, 8'h05, 8'h00, 8'h1E, 8'hA5});
    apb(1'b1, ccfc_pkg::OFS_LINK_CTRL, 32'h0000_0005);
    send({8'hA0, 8'h00, 8'h1E, 8'h00}, 1'b0);
    wait_idle();
    chk("stack off", 32'h0000_0000, txq.size());
  endtask : t_stack
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (shd[i]) shd[i] = 8'h00;
    {clock, psel, penable, pwrite, rx_valid} = 5'h00;
    {paddr, pwdata, rx_data} = 52'h0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_write();
    t_badcrc();
    t_read();
    t_other();
    t_stack();
    give_verdict();
  end
  // watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    #1_000_000;
    miscompares++;
    give_verdict();
  end
endmodule : test_chain_command_frame_crc
`default_nettype wire
